/* File: design/pin_port_params.svh */
/*
  Register offsets, reset values and field layouts of the pin port.
  Assumes a 32-bit APB slave with byte addresses and word registers.
*/
`ifndef PIN_PORT_PARAMS_SVH
`define PIN_PORT_PARAMS_SVH

`define OFS_OUTPUT_VALUE 8'h00
`define OFS_CODE_LOW 8'h04
`define OFS_CODE_MID 8'h08
`define OFS_CODE_HIGH 8'h0c
`define OFS_FABRIC_OUT_EN 8'h10
`define OFS_FABRIC_IN_EN 8'h14
`define OFS_PIN_STATE 8'h18
`define OFS_IRQ_STATUS 8'h1c
`define OFS_IRQ_MASK 8'h20
`define OFS_RISE_EN 8'h24
`define OFS_FALL_EN 8'h28
`define OFS_RESET_CONFIG 8'h2c
`define OFS_THRESHOLD 8'h30

`define ADDR_LSB 2
`define ADDR_MSB 7

`define RST_CFG_WIDTH 2
`define RST_CFG_NONE 2'h0
`define RST_CFG_PULL_DOWN 2'h1
`define RST_CFG_PULL_UP 2'h2

`define DRIVE_OE 3
`define DRIVE_OUT 2
`define DRIVE_PU 1
`define DRIVE_PD 0

`endif

/* File: design/pin_port_pkg.sv */
/*
  Types shared by the pin port: drive codes and the start-up sequence.
  Assumes pin_port_params.svh is on the include path.
*/
package pin_port_pkg;

  typedef enum logic [2:0] {
    DM_ANALOG_HIZ = 3'b000,
    DM_DIGITAL_HIZ = 3'b001,
    DM_RES_PULL_UP = 3'b010,
    DM_RES_PULL_DOWN = 3'b011,
    DM_OPEN_DRAIN_LOW = 3'b100,
    DM_OPEN_DRAIN_HIGH = 3'b101,
    DM_STRONG = 3'b110,
    DM_RES_BOTH = 3'b111
  } drive_mode_type;

  typedef enum logic [0:0] {
    BOOT_LOAD = 1'b0,
    BOOT_RUN = 1'b1
  } boot_state_type;

endpackage

/* File: design/pin_drive_mode_port.sv */
/*
  One I/O port: per-pin drive mode, output source selection, pin sampling,
  pin-change interrupts with wakeup, reset configuration load and shared
  input thresholds for pin pairs, all reached over APB.
  Assumes pins, fabric signals and nonvolatile data are synchronous to
  ref_clk, and that the pad turns oe, out, pull_up and pull_down into a
  pin level.
*/
// Our own choices: the register addresses and the APB interface to the registers.
`timescale 1ns/1ps
`include "pin_port_params.svh"

module pin_drive_mode_port
  import pin_port_pkg::*;
#(
  parameter int PINS = 8,
  parameter int THR_W = 4
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [PINS-1:0] pin_in,
  output logic [PINS-1:0] pin_out,
  output logic [PINS-1:0] pin_oe,
  output logic [PINS-1:0] pin_pull_up,
  output logic [PINS-1:0] pin_pull_down,
  input wire logic [PINS-1:0] fabric_out,
  output logic [PINS-1:0] fabric_in,
  input wire logic [`RST_CFG_WIDTH-1:0] nv_reset_config,
  input wire logic low_power,
  output logic [PINS*THR_W-1:0] pin_threshold,
  output logic irq,
  output logic wakeup_req
);

  localparam int PAIRS = PINS / 2;

  // Software registers, sampled pin state and boot state.
  logic [PINS-1:0] port_output_value;
  logic [PINS-1:0] drive_code_bit_low;
  logic [PINS-1:0] drive_code_bit_mid;
  logic [PINS-1:0] drive_code_bit_high;
  logic [PINS-1:0] fabric_out_enable;
  logic [PINS-1:0] fabric_in_enable;
  logic [PINS-1:0] irq_status;
  logic [PINS-1:0] irq_mask;
  logic [PINS-1:0] rise_enable;
  logic [PINS-1:0] fall_enable;
  logic [`RST_CFG_WIDTH-1:0] reset_config;
  logic [PAIRS*THR_W-1:0] threshold_pairs;
  logic [PINS-1:0] pin_state;
  logic [PINS-1:0] prev_state;
  boot_state_type boot_state;

  logic [PINS-1:0] next_port_output_value;
  logic [PINS-1:0] next_drive_code_bit_low;
  logic [PINS-1:0] next_drive_code_bit_mid;
  logic [PINS-1:0] next_drive_code_bit_high;
  logic [PINS-1:0] next_fabric_out_enable;
  logic [PINS-1:0] next_fabric_in_enable;
  logic [PINS-1:0] next_irq_status;
  logic [PINS-1:0] next_irq_mask;
  logic [PINS-1:0] next_rise_enable;
  logic [PINS-1:0] next_fall_enable;
  logic [`RST_CFG_WIDTH-1:0] next_reset_config;
  logic [PAIRS*THR_W-1:0] next_threshold_pairs;
  logic [PINS-1:0] next_pin_state;
  logic [PINS-1:0] next_prev_state;
  boot_state_type next_boot_state;
  logic [31:0] next_prdata;
  logic next_pready;
  logic next_pslverr;
  logic next_irq;
  logic next_wakeup_req;

  // Pin-facing state.
  logic [PINS-1:0] next_pin_out;
  logic [PINS-1:0] next_pin_oe;
  logic [PINS-1:0] next_pin_pull_up;
  logic [PINS-1:0] next_pin_pull_down;
  logic [PINS-1:0] next_fabric_in;
  logic [PINS*THR_W-1:0] next_pin_threshold;

  // Decodes a word address; returns one when a register sits there.
  function automatic logic addr_known(input logic [31:0] addr);
    logic [7:0] ofs;
    ofs = addr[7:0];
    addr_known = (addr[31:8] == 24'h000000) &&
                 (ofs[`ADDR_LSB-1:0] == 2'h0) &&
                 (ofs <= `OFS_THRESHOLD);
  endfunction

  // Pad controls {oe, out, pull_up, pull_down} for a code and output bit.
  function automatic logic [3:0] drive_pad(input logic [2:0] code,
                                           input logic bit_value);
    logic [3:0] pad;
    pad = 4'h0;
    unique case (drive_mode_type'(code))
      DM_ANALOG_HIZ, DM_DIGITAL_HIZ: begin
        pad = 4'h0;
      end
      DM_RES_PULL_UP: begin
        pad = bit_value ? 4'b0010 : 4'b1000;
      end
      DM_RES_PULL_DOWN: begin
        pad = bit_value ? 4'b1100 : 4'b0001;
      end
      DM_OPEN_DRAIN_LOW: begin
        pad = bit_value ? 4'b0000 : 4'b1000;
      end
      DM_OPEN_DRAIN_HIGH: begin
        pad = bit_value ? 4'b1100 : 4'b0000;
      end
      DM_STRONG: begin
        pad = {1'b1, bit_value, 2'b00};
      end
      DM_RES_BOTH: begin
        pad = bit_value ? 4'b0010 : 4'b0001;
      end
    endcase
    drive_pad = pad;
  endfunction

  // Bus, register and interrupt next values.
  always_comb begin
    logic setup;
    logic access;
    logic wr;
    logic [7:0] ofs;
    logic [PINS-1:0] events;
    logic [PINS-1:0] wdata;
    setup = 1'b0;
    access = 1'b0;
    wr = 1'b0;
    ofs = 8'h00;
    events = '0;
    wdata = '0;
    next_port_output_value = port_output_value;
    next_drive_code_bit_low = drive_code_bit_low;
    next_drive_code_bit_mid = drive_code_bit_mid;
    next_drive_code_bit_high = drive_code_bit_high;
    next_fabric_out_enable = fabric_out_enable;
    next_fabric_in_enable = fabric_in_enable;
    next_irq_mask = irq_mask;
    next_rise_enable = rise_enable;
    next_fall_enable = fall_enable;
    next_reset_config = reset_config;
    next_threshold_pairs = threshold_pairs;
    next_boot_state = boot_state;
    next_prdata = prdata;
    next_pslverr = pslverr;
    next_pin_state = pin_in;
    next_prev_state = pin_state;

    // Edge detection keeps running in low power so a pin can wake the chip.
    events = (pin_state & ~prev_state & rise_enable) |
             (~pin_state & prev_state & fall_enable);

    setup = psel && !penable;
    access = psel && penable && pready;
    wr = access && pwrite && addr_known(paddr);
    ofs = paddr[7:0];
    wdata = pwdata[PINS-1:0];

    // Zero wait states: the answer is prepared in the setup cycle.
    next_pready = setup;
    if (setup) begin
      next_pslverr = !addr_known(paddr);
      next_prdata = 32'h00000000;
      if (addr_known(paddr)) begin
        unique case (ofs)
          `OFS_OUTPUT_VALUE: next_prdata[PINS-1:0] = port_output_value;
          `OFS_CODE_LOW: next_prdata[PINS-1:0] = drive_code_bit_low;
          `OFS_CODE_MID: next_prdata[PINS-1:0] = drive_code_bit_mid;
          `OFS_CODE_HIGH: next_prdata[PINS-1:0] = drive_code_bit_high;
          `OFS_FABRIC_OUT_EN: next_prdata[PINS-1:0] = fabric_out_enable;
          `OFS_FABRIC_IN_EN: next_prdata[PINS-1:0] = fabric_in_enable;
          `OFS_PIN_STATE: next_prdata[PINS-1:0] = pin_state;
          `OFS_IRQ_STATUS: next_prdata[PINS-1:0] = irq_status;
          `OFS_IRQ_MASK: next_prdata[PINS-1:0] = irq_mask;
          `OFS_RISE_EN: next_prdata[PINS-1:0] = rise_enable;
          `OFS_FALL_EN: next_prdata[PINS-1:0] = fall_enable;
          `OFS_RESET_CONFIG: begin
            next_prdata[`RST_CFG_WIDTH-1:0] = reset_config;
          end
          `OFS_THRESHOLD: begin
            next_prdata[PAIRS*THR_W-1:0] = threshold_pairs;
          end
          default: next_prdata = 32'h00000000;
        endcase
      end
    end else if (access) begin
      next_pslverr = 1'b0;
    end

    if (wr) begin
      unique case (ofs)
        `OFS_OUTPUT_VALUE: next_port_output_value = wdata;
        `OFS_CODE_LOW: next_drive_code_bit_low = wdata;
        `OFS_CODE_MID: next_drive_code_bit_mid = wdata;
        `OFS_CODE_HIGH: next_drive_code_bit_high = wdata;
        `OFS_FABRIC_OUT_EN: next_fabric_out_enable = wdata;
        `OFS_FABRIC_IN_EN: next_fabric_in_enable = wdata;
        `OFS_IRQ_MASK: next_irq_mask = wdata;
        `OFS_RISE_EN: next_rise_enable = wdata;
        `OFS_FALL_EN: next_fall_enable = wdata;
        `OFS_THRESHOLD: begin
          next_threshold_pairs = pwdata[PAIRS*THR_W-1:0];
        end
        default: next_reset_config = reset_config;
      endcase
    end

    // A new event wins over a write-one-to-clear in the same cycle.
    next_irq_status = irq_status;
    if (wr && ofs == `OFS_IRQ_STATUS) begin
      next_irq_status = irq_status & ~wdata;
    end
    next_irq_status = next_irq_status | events;

    // The nonvolatile image is caught one edge after reset release.
    unique case (boot_state)
      BOOT_LOAD: begin
        next_boot_state = BOOT_RUN;
        next_reset_config = nv_reset_config;
        if (nv_reset_config == `RST_CFG_PULL_UP) begin
          next_drive_code_bit_high = '0;
          next_drive_code_bit_mid = '1;
          next_drive_code_bit_low = '0;
          next_port_output_value = '1;
        end else if (nv_reset_config == `RST_CFG_PULL_DOWN) begin
          next_drive_code_bit_high = '0;
          next_drive_code_bit_mid = '1;
          next_drive_code_bit_low = '1;
          next_port_output_value = '0;
        end
      end
      BOOT_RUN: begin
        next_boot_state = BOOT_RUN;
      end
    endcase

    next_irq = |(next_irq_status & next_irq_mask);
    next_wakeup_req = low_power && next_irq;
  end

  // Pin drive next values.
  always_comb begin
    logic [2:0] code;
    logic bit_value;
    logic [3:0] pad;
    code = 3'h0;
    bit_value = 1'b0;
    pad = 4'h0;
    next_pin_out = pin_out;
    next_pin_oe = pin_oe;
    next_pin_pull_up = pin_pull_up;
    next_pin_pull_down = pin_pull_down;
    next_fabric_in = pin_state & fabric_in_enable;
    for (int i = 0; i < PINS; i++) begin
      code = {drive_code_bit_high[i], drive_code_bit_mid[i],
              drive_code_bit_low[i]};
      bit_value = fabric_out_enable[i] ? fabric_out[i] :
                  port_output_value[i];
      pad = drive_pad(code, bit_value);
      // Pads freeze in low power; the fabric may stop or glitch then.
      if (!low_power) begin
        next_pin_oe[i] = pad[`DRIVE_OE];
        next_pin_out[i] = pad[`DRIVE_OUT];
        next_pin_pull_up[i] = pad[`DRIVE_PU];
        next_pin_pull_down[i] = pad[`DRIVE_PD];
      end
    end
    for (int p = 0; p < PAIRS; p++) begin
      next_pin_threshold[2*p*THR_W +: THR_W] =
        threshold_pairs[p*THR_W +: THR_W];
      next_pin_threshold[(2*p+1)*THR_W +: THR_W] =
        threshold_pairs[p*THR_W +: THR_W];
    end
    if (PINS > 2 * PAIRS) begin
      next_pin_threshold[PINS*THR_W-1 -: THR_W] = '0;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      port_output_value <= '0;
      drive_code_bit_low <= '0;
      drive_code_bit_mid <= '0;
      drive_code_bit_high <= '0;
      fabric_out_enable <= '0;
      fabric_in_enable <= '0;
      irq_status <= '0;
      irq_mask <= '0;
      rise_enable <= '0;
      fall_enable <= '0;
      reset_config <= `RST_CFG_NONE;
      threshold_pairs <= '0;
      pin_state <= '0;
      prev_state <= '0;
      boot_state <= BOOT_LOAD;
      prdata <= 32'h00000000;
      pready <= 1'b0;
      pslverr <= 1'b0;
      irq <= 1'b0;
      wakeup_req <= 1'b0;
    end else begin
      port_output_value <= next_port_output_value;
      drive_code_bit_low <= next_drive_code_bit_low;
      drive_code_bit_mid <= next_drive_code_bit_mid;
      drive_code_bit_high <= next_drive_code_bit_high;
      fabric_out_enable <= next_fabric_out_enable;
      fabric_in_enable <= next_fabric_in_enable;
      irq_status <= next_irq_status;
      irq_mask <= next_irq_mask;
      rise_enable <= next_rise_enable;
      fall_enable <= next_fall_enable;
      reset_config <= next_reset_config;
      threshold_pairs <= next_threshold_pairs;
      pin_state <= next_pin_state;
      prev_state <= next_prev_state;
      boot_state <= next_boot_state;
      prdata <= next_prdata;
      pready <= next_pready;
      pslverr <= next_pslverr;
      irq <= next_irq;
      wakeup_req <= next_wakeup_req;
    end
  end

  // Reset overrides low-power hold so pads go to code 0 at once.
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      pin_out <= '0;
      pin_oe <= '0;
      pin_pull_up <= '0;
      pin_pull_down <= '0;
      fabric_in <= '0;
      pin_threshold <= '0;
    end else begin
      pin_out <= next_pin_out;
      pin_oe <= next_pin_oe;
      pin_pull_up <= next_pin_pull_up;
      pin_pull_down <= next_pin_pull_down;
      fabric_in <= next_fabric_in;
      pin_threshold <= next_pin_threshold;
    end
  end

endmodule // pin_drive_mode_port

/* File: verification/pin_port_sva.sv */
/*
  Checker for the pin port: APB handshake, pad states, wakeup, input path.
  Assumes it is bound into pin_drive_mode_port and sees only its ports.
*/
`timescale 1ns/1ps
module pin_port_sva #(
  parameter int PINS = 8
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [PINS-1:0] pin_in,
  input wire logic [PINS-1:0] pin_out,
  input wire logic [PINS-1:0] pin_oe,
  input wire logic [PINS-1:0] pin_pull_up,
  input wire logic [PINS-1:0] pin_pull_down,
  input wire logic [PINS-1:0] fabric_in,
  input wire logic low_power,
  input wire logic irq,
  input wire logic wakeup_req
);
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (rst);
  sequence s_setup;
    psel && !penable;
  endsequence
  sequence s_access;
    psel && penable && pready;
  endsequence
  sequence s_pads_off;
    pin_oe == '0 && pin_pull_up == '0 && pin_pull_down == '0;
  endsequence
  a_setup_gets_ready: assert property (s_setup |=> s_access)
    else $error("access phase without ready");
  a_ready_one_cycle: assert property (pready |=> !pready)
    else $error("ready held longer than one cycle");
  a_error_with_ready: assert property (pslverr |-> pready)
    else $error("error without ready");
  a_reset_pads_off: assert property (
    $fell(rst) |-> s_pads_off ##1 s_pads_off)
    else $error("pads driven right after reset");
  a_drive_pull_apart: assert property (
    (pin_oe & (pin_pull_up | pin_pull_down)) == '0 &&
    (pin_pull_up & pin_pull_down) == '0)
    else $error("strong drive and pull together");
  a_low_power_hold: assert property (low_power |=>
    $stable(pin_oe) && $stable(pin_out) && $stable(pin_pull_up) &&
    $stable(pin_pull_down))
    else $error("pads changed in low power");
  a_wake_needs_irq: assert property (
    wakeup_req |-> irq && $past(low_power))
    else $error("wakeup without pending interrupt");
  a_fabric_in_src: assert property (
    (fabric_in & ~$past(pin_in, 2)) == '0)
    else $error("fabric input not from pin level");
endmodule // pin_port_sva

bind pin_drive_mode_port pin_port_sva #(.PINS(PINS)) sva_inst (
  .ref_clk, .rst, .psel, .penable, .pready, .pslverr, .pin_in, .pin_out,
  .pin_oe, .pin_pull_up, .pin_pull_down, .fabric_in, .low_power, .irq,
  .wakeup_req);

/* File: verification/pin_board.sv */
/*
  Board model at the pins: resolves each level from pad drive, pulls and
  an external driver. Assumes its inputs change just after ref_clk edges.
*/
`timescale 1ns/1ps
module pin_board (
  input wire logic ref_clk,
  input wire logic [7:0] drv_oe,
  input wire logic [7:0] drv_out,
  input wire logic [7:0] pu,
  input wire logic [7:0] pd,
  input wire logic [7:0] ext_en,
  input wire logic [7:0] ext_val,
  output logic [7:0] level
);
  // A floating pin wanders every cycle so a settled unknown cannot pass.
  logic [7:0] drift = 8'h5a;
  always @(posedge ref_clk) begin
    drift <= ~drift;
  end
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      if (drv_oe[i]) level[i] = drv_out[i];
      else if (ext_en[i]) level[i] = ext_val[i];
      else if (pu[i]) level[i] = 1'b1;
      else if (pd[i]) level[i] = 1'b0;
      else level[i] = drift[i];
    end
  end
endmodule // pin_board

/* File: verification/pin_drive_mode_port_test.sv */
/*
  Self-checking bench for the pin port over APB with a board model.
  Assumes the design files and pin_port_params.svh are compiled first.
*/
`timescale 1ns/1ps
`include "pin_port_params.svh"
module pin_drive_mode_port_test
  import pin_port_pkg::*;
;
  logic ref_clk, rst, psel, penable, pwrite, low_power, irq, wakeup_req;
  logic pready, pslverr, err;
  logic [31:0] paddr, pwdata, prdata, pin_threshold, rdat, thr;
  logic [7:0] pin_in, pin_out, pin_oe, pin_pull_up, pin_pull_down;
  logic [7:0] fabric_out, fabric_in, ext_en, ext_val, rnd, dr, foe;
  logic [15:0] tv;
  logic [1:0] nv_reset_config;
  int code [8];
  int num_errors, checks_done;
  pin_drive_mode_port #(.PINS(8), .THR_W(4)) DUT (.ref_clk, .rst, .psel,
    .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .pin_in, .pin_out, .pin_oe, .pin_pull_up, .pin_pull_down, .fabric_out,
    .fabric_in, .nv_reset_config, .low_power, .pin_threshold, .irq,
    .wakeup_req);
  pin_board board (.ref_clk, .drv_oe(pin_oe), .drv_out(pin_out),
    .pu(pin_pull_up), .pd(pin_pull_down), .ext_en, .ext_val,
    .level(pin_in));
  initial begin
    ref_clk = 1'b0;
    forever #12.5 ref_clk = ~ref_clk;
  end
  function automatic logic [7:0] lfsr_next(logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction
  function automatic logic [3:0] pad(int c, logic v);
    case (c)
      2: return v ? 4'b0010 : 4'b1000;
      3: return v ? 4'b1100 : 4'b0001;
      4: return v ? 4'b0000 : 4'b1000;
      5: return v ? 4'b1100 : 4'b0000;
      6: return {1'b1, v, 2'b00};
      7: return v ? 4'b0010 : 4'b0001;
      default: return 4'b0000;
    endcase
  endfunction
  task automatic chk(string nm, logic [31:0] exp, logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      $display("FAIL %s expected %h seen %h", nm, exp, got);
      num_errors++;
    end
  endtask
  task automatic apb(logic w, logic [7:0] a, logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {24'h0, a};
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    @(posedge ref_clk);
    // Only the watchdog ends a wait that never sees ready.
    while (pready !== 1'b1) begin
      @(posedge ref_clk);
    end
    rdat = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge ref_clk);
  endtask
  task automatic wr(logic [7:0] a, logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rd(string nm, logic [7:0] a, logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(nm, exp, rdat);
    chk({nm, " error"}, 32'h0, {31'h0, err});
  endtask
  task automatic setc;
    logic [7:0] b [3];
    for (int i = 0; i < 8; i++)
      for (int k = 0; k < 3; k++) b[k][i] = code[i][k];
    wr(`OFS_CODE_LOW, {24'h0, b[0]});
    wr(`OFS_CODE_MID, {24'h0, b[1]});
    wr(`OFS_CODE_HIGH, {24'h0, b[2]});
    wr(`OFS_OUTPUT_VALUE, {24'h0, dr});
  endtask
  task automatic pads(string nm);
    logic [3:0] f;
    logic [31:0] ex;
    repeat (2) @(negedge ref_clk);
    for (int i = 0; i < 8; i++) begin
      f = pad(code[i], foe[i] ? fabric_out[i] : dr[i]);
      for (int k = 0; k < 4; k++) ex[k*8+i] = f[k];
    end
    chk(nm, ex & {8'hff, ex[31:24], 16'hffff}, {pin_oe,
      pin_out & pin_oe, pin_pull_up, pin_pull_down});
    @(posedge ref_clk);
  endtask
  task automatic finish_test;
    $display("comparisons %0d mismatches %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge ref_clk);
    num_errors++;
    finish_test();
  end
  initial begin
    {rst, psel, penable, pwrite, low_power} = 5'b10000;
    {paddr, pwdata, fabric_out, ext_en, ext_val} = '0;
    {num_errors, checks_done} = '0;
    rnd = 8'h02;
    nv_reset_config = `RST_CFG_PULL_UP;
    repeat (12) @(posedge ref_clk);
    rst <= 1'b0;
    repeat (2) @(posedge ref_clk);
    foreach (code[i]) code[i] = 2;
    {dr, foe} = 16'hff00;
    pads("boot pull-up");
    rd("reset config", `OFS_RESET_CONFIG, 32'h2);
    for (int c = 0; c < 16; c++) begin
      rnd = lfsr_next(rnd);
      dr = rnd;
      foreach (code[i]) code[i] = (c + i) % 8;
      setc();
      pads("drive code");
    end
    $display("test drive codes finished");
    fabric_out <= ~rnd;
    foe = 8'h5a;
    foreach (code[i]) code[i] = DM_STRONG;
    setc();
    wr(`OFS_FABRIC_OUT_EN, 32'h5a);
    pads("fabric select");
    fabric_out <= rnd;
    pads("fabric follow");
    foreach (code[i]) code[i] = DM_DIGITAL_HIZ;
    setc();
    ext_en <= 8'hff;
    ext_val <= rnd;
    wr(`OFS_FABRIC_IN_EN, 32'h3c);
    wr(`OFS_PIN_STATE, 32'h0);
    rd("pin state", `OFS_PIN_STATE, {24'h0, rnd});
    chk("fabric in", {24'h0, rnd & 8'h3c}, {24'h0, fabric_in});
    $display("test input path finished");
    // Board-driven pins stay in a floating code so the pad never fights.
    foreach (code[i]) code[i] = i < 4 ? 1 : 6;
    {dr, foe} = 16'h0;
    wr(`OFS_FABRIC_OUT_EN, 32'h0);
    setc();
    ext_en <= 8'h0f;
    ext_val <= 8'h00;
    wr(`OFS_RISE_EN, 32'h0f);
    wr(`OFS_FALL_EN, 32'h0);
    wr(`OFS_IRQ_STATUS, 32'hff);
    wr(`OFS_IRQ_MASK, 32'h01);
    rd("status clear", `OFS_IRQ_STATUS, 32'h0);
    ext_val <= 8'h05;
    repeat (4) @(posedge ref_clk);
    chk("irq", 32'h1, {31'h0, irq});
    rd("status", `OFS_IRQ_STATUS, 32'h5);
    wr(`OFS_IRQ_MASK, 32'h02);
    @(posedge ref_clk);
    chk("irq masked", 32'h0, {31'h0, irq});
    wr(`OFS_IRQ_STATUS, 32'h05);
    rd("status w1c", `OFS_IRQ_STATUS, 32'h0);
    low_power <= 1'b1;
    wr(`OFS_OUTPUT_VALUE, 32'hf0);
    pads("low power hold");
    ext_val <= 8'h07;
    repeat (5) @(posedge ref_clk);
    chk("wakeup", 32'h3, {30'h0, wakeup_req, irq});
    low_power <= 1'b0;
    dr = 8'hf0;
    pads("wake release");
    $display("test interrupts finished");
    rnd = lfsr_next(rnd);
    tv = {rnd, ~rnd};
    wr(`OFS_THRESHOLD, {16'h0, tv});
    for (int i = 0; i < 8; i++) thr[i*4 +: 4] = tv[(i/2)*4 +: 4];
    @(negedge ref_clk);
    chk("threshold", thr, pin_threshold);
    @(posedge ref_clk);
    apb(1'b0, 8'h34, 32'h0);
    chk("unmapped", 32'h1, {rdat[30:0], err});
    nv_reset_config <= `RST_CFG_PULL_DOWN;
    rst <= 1'b1;
    repeat (3) @(negedge ref_clk);
    chk("reset pads", 32'h0, {pin_oe, pin_pull_up, pin_pull_down, 8'h0});
    @(posedge ref_clk);
    rst <= 1'b0;
    repeat (2) @(posedge ref_clk);
    foreach (code[i]) code[i] = 3;
    {dr, foe} = 16'h0;
    pads("boot pull-down");
    rd("reset config", `OFS_RESET_CONFIG, 32'h1);
    $display("test reset finished");
    finish_test();
  end
endmodule // pin_drive_mode_port_test
